//--- rtl/usf_regs.v
// Purpose: channel register bank with flow character registers and status
// Assumes: one clk at 250 MHz, synchronous active high reset, plain reg port
// Notes: engines outside report flow events and line state as pulses/levels
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "usf_map.vh"
module usf_regs (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire bclk_tick,
  input wire tx_resume_sent,
  input wire tx_stop_sent,
  input wire rx_resume_seen,
  input wire rx_stop_seen,
  input wire rx_char_done,
  input wire [7:0] rx_char,
  input wire [3:0] modem_in_n,
  input wire [7:0] tx_fifo_count,
  input wire [7:0] rx_fifo_count,
  input wire tx_idle,
  input wire tx_serial,
  input wire tx_serial_en,
  output reg serial_out,
  output reg infrared_tx_out,
  output reg rts_n,
  output reg dtr_n,
  output wire [7:0] stop_char_first_o,
  output wire [7:0] stop_char_second_o,
  output wire [7:0] resume_char_first_o,
  output wire [7:0] resume_char_second_o,
  output wire [3:0] tx_flow_sel,
  output wire [3:0] rx_flow_sel,
  output wire [7:0] transmit_holding_o,
  output reg transmit_load,
  output wire irq
);
  // software writable registers, and the receive holding register
  reg [7:0] baud_divisor_low;
  reg [7:0] baud_divisor_high;
  reg [7:0] baud_divisor_fraction;
  reg [7:0] interrupt_enable_reg;
  reg [7:0] fifo_control_reg;
  reg [7:0] line_control_reg;
  reg [7:0] modem_control_reg;
  reg [7:0] scratch_reg;
  reg [7:0] feature_control_reg;
  reg [7:0] enhanced_feature_reg;
  reg [7:0] tx_fifo_threshold;
  reg [7:0] rx_fifo_threshold;
  reg [7:0] stop_char_first;
  reg [7:0] stop_char_second;
  reg [7:0] resume_char_first;
  reg [7:0] resume_char_second;
  reg [3:0] flow_select;
  reg [7:0] receive_holding;
  reg [7:0] transmit_holding;
  // status state, plus the irq mask and the read mux
  reg rx_ready;
  reg [3:0] modem_prev;
  reg [3:0] modem_delta;
  reg [1:0] modem_primed;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [7:0] next_rdata;
  reg [7:0] interrupt_source_reg;
  wire [7:0] line_status_reg;
  wire [7:0] modem_status_reg;
  wire [3:0] modem_lvl_n;
  wire [3:0] modem_lvl;
  wire [7:0] flow_char_status;
  wire flow_enabled;
  wire rd_flowstat;
  wire flow_event;
  wire rx_int;

  // modem inputs come from pins: two flops before use
  usf_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .din(modem_in_n),
    .dout(modem_lvl_n)
  );
  assign modem_lvl = ~modem_lvl_n;

  // all four select bits zero means no software flow control
  assign flow_enabled = |enhanced_feature_reg[3:0];
  assign tx_flow_sel = {2'b00, enhanced_feature_reg[3:2]};
  assign rx_flow_sel = {2'b00, enhanced_feature_reg[1:0]};
  assign rd_flowstat = rd && (addr == `USF_ADDR_FLOWSTAT);
  assign flow_event = tx_resume_sent | tx_stop_sent | rx_resume_seen | rx_stop_seen;

  usf_flowstat u_flowstat (
    .clk(clk),
    .rst(rst),
    .flow_enabled(flow_enabled),
    .clear_rd(rd_flowstat),
    .tx_resume_sent(tx_resume_sent),
    .tx_stop_sent(tx_stop_sent),
    .rx_resume_seen(rx_resume_seen),
    .rx_stop_seen(rx_stop_seen),
    .status(flow_char_status)
  );

  // flow characters go to the engines, never back to the bus
  assign stop_char_first_o = stop_char_first;
  assign stop_char_second_o = stop_char_second;
  assign resume_char_first_o = resume_char_first;
  assign resume_char_second_o = resume_char_second;
  assign transmit_holding_o = transmit_holding;

  // register writes and reset values
  always @(posedge clk) begin
    if (rst) begin
      baud_divisor_low <= `USF_RST_DIVLO;
      baud_divisor_high <= `USF_RST_ZERO;
      baud_divisor_fraction <= `USF_RST_ZERO;
      interrupt_enable_reg <= `USF_RST_ZERO;
      fifo_control_reg <= `USF_RST_ZERO;
      line_control_reg <= `USF_RST_ZERO;
      modem_control_reg <= `USF_RST_ZERO;
      feature_control_reg <= `USF_RST_ZERO;
      enhanced_feature_reg <= `USF_RST_ZERO;
      tx_fifo_threshold <= `USF_RST_ZERO;
      rx_fifo_threshold <= `USF_RST_ZERO;
      stop_char_first <= `USF_RST_ZERO;
      stop_char_second <= `USF_RST_ZERO;
      resume_char_first <= `USF_RST_ZERO;
      resume_char_second <= `USF_RST_ZERO;
      scratch_reg <= `USF_RST_SPR;
      flow_select <= 4'h0;
      irq_mask <= 2'b00;
    end else if (wr) begin
      case (addr)
        `USF_ADDR_IER: interrupt_enable_reg <= wdata;
        `USF_ADDR_FCR_ISR: fifo_control_reg <= wdata;
        `USF_ADDR_LCR: line_control_reg <= wdata;
        `USF_ADDR_MCR: modem_control_reg <= wdata;
        `USF_ADDR_SPR: scratch_reg <= wdata;
        `USF_ADDR_DIVLO: baud_divisor_low <= wdata;
        `USF_ADDR_DIVHI: baud_divisor_high <= wdata;
        `USF_ADDR_DIVFR: baud_divisor_fraction <= wdata;
        `USF_ADDR_FEATURE_CONTROL_REG: feature_control_reg <= wdata;
        `USF_ADDR_EFR: enhanced_feature_reg <= wdata;
        `USF_ADDR_FLOWSEL: flow_select <= wdata[3:0];
        `USF_ADDR_IRQ: irq_mask <= wdata[5:4]; // same place as on read
        `USF_ADDR_FLOWSTAT: begin
          // data slot for whichever character or threshold register is selected; level selects take no write
          case (flow_select)
            `USF_SEL_STOP1: stop_char_first <= wdata;
            `USF_SEL_STOP2: stop_char_second <= wdata;
            `USF_SEL_RES1: resume_char_first <= wdata;
            `USF_SEL_RES2: resume_char_second <= wdata;
            `USF_SEL_TXTRG: tx_fifo_threshold <= wdata;
            `USF_SEL_RXTRG: rx_fifo_threshold <= wdata;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // holding registers carry no reset: contents undefined until used
  always @(posedge clk) begin
    if (wr && addr == `USF_ADDR_HOLDING) begin
      transmit_holding <= wdata;
    end
    if (rx_char_done) begin
      receive_holding <= rx_char;
    end
  end

  // transmit load strobe and receive ready flag
  always @(posedge clk) begin
    if (rst) begin
      transmit_load <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      transmit_load <= wr && (addr == `USF_ADDR_HOLDING);
      if (rx_char_done) begin
        rx_ready <= 1'b1; // set wins over the read below
      end else if (rd && addr == `USF_ADDR_HOLDING) begin
        rx_ready <= 1'b0;
      end
    end
  end

  // line status: holding and shifter empty bits from the transmit side
  assign line_status_reg = {1'b0, tx_idle, tx_idle, 4'h0, rx_ready};

  // modem change bits; history primed until the synchroniser has filled,
  // else a pin held active through reset would look like a change
  always @(posedge clk) begin
    if (rst) begin
      modem_prev <= 4'h0;
      modem_delta <= 4'h0;
      modem_primed <= 2'b00;
    end else begin
      modem_prev <= modem_lvl;
      if (modem_primed != 2'b11) begin
        modem_primed <= modem_primed + 2'b01;
      end
      if ((modem_primed == 2'b11) && (modem_prev != modem_lvl)) begin
        modem_delta <= modem_delta | (modem_prev ^ modem_lvl);
      end else if (rd && addr == `USF_ADDR_MSR) begin
        modem_delta <= 4'h0;
      end
    end
  end
  assign modem_status_reg = {modem_lvl, modem_delta}; // levels live

  // receive interrupt raised the cycle after character done, once rx_ready is set, inside one tick
  assign rx_int = rx_ready & interrupt_enable_reg[0];

  // interrupt source: 0x01 means no enabled receive interrupt pending
  always @* begin
    if (rx_int) begin
      interrupt_source_reg = 8'h04;
    end else begin
      interrupt_source_reg = `USF_RST_ISR;
    end
  end

  // sticky block events, cleared by reading the irq register; set wins
  always @(posedge clk) begin
    if (rst) begin
      irq_status <= 2'b00;
    end else begin
      irq_status[`USF_IRQ_FLOW] <= flow_event |
        (irq_status[`USF_IRQ_FLOW] & ~(rd && addr == `USF_ADDR_IRQ));
      irq_status[`USF_IRQ_RX] <= rx_char_done |
        (irq_status[`USF_IRQ_RX] & ~(rd && addr == `USF_ADDR_IRQ));
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read mux; the write-only flow character slots read the flow status
  always @* begin
    case (addr)
      `USF_ADDR_HOLDING: next_rdata = receive_holding;
      `USF_ADDR_IER: next_rdata = interrupt_enable_reg;
      `USF_ADDR_FCR_ISR: next_rdata = interrupt_source_reg;
      `USF_ADDR_LCR: next_rdata = line_control_reg;
      `USF_ADDR_MCR: next_rdata = modem_control_reg;
      `USF_ADDR_LSR: next_rdata = line_status_reg;
      `USF_ADDR_MSR: next_rdata = modem_status_reg;
      `USF_ADDR_SPR: next_rdata = scratch_reg;
      `USF_ADDR_DIVLO: next_rdata = baud_divisor_low;
      `USF_ADDR_DIVHI: next_rdata = baud_divisor_high;
      `USF_ADDR_DIVFR: next_rdata = baud_divisor_fraction;
      `USF_ADDR_FEATURE_CONTROL_REG: next_rdata = feature_control_reg;
      `USF_ADDR_EFR: next_rdata = enhanced_feature_reg;
      `USF_ADDR_FLOWSEL: next_rdata = {4'h0, flow_select};
      `USF_ADDR_FLOWSTAT: begin
        case (flow_select)
          `USF_SEL_TXLVL: next_rdata = tx_fifo_count;
          `USF_SEL_TXTRG: next_rdata = tx_fifo_threshold;
          `USF_SEL_RXLVL: next_rdata = rx_fifo_count;
          `USF_SEL_RXTRG: next_rdata = rx_fifo_threshold;
          default: next_rdata = flow_char_status;
        endcase
      end
      `USF_ADDR_IRQ: next_rdata = {2'b00, irq_mask, 2'b00, irq_status};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stands the cycle after the strobe only
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // pin outputs: idle levels under reset, then driven by engine and control
  always @(posedge clk) begin
    if (rst) begin
      serial_out <= 1'b1;
      infrared_tx_out <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      serial_out <= tx_serial_en ? tx_serial : 1'b1;
      infrared_tx_out <= tx_serial_en & ~tx_serial & feature_control_reg[4];
      rts_n <= ~modem_control_reg[1];
      dtr_n <= ~modem_control_reg[0];
    end
  end
endmodule // usf_regs
`default_nettype wire

//--- rtl/usf_map.vh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: one serial channel, 8-bit register port
// Notes: included by every design file of the block except usf_sync
`ifndef USF_MAP_VH
`define USF_MAP_VH

// register offsets (4-bit address)
`define USF_ADDR_HOLDING 4'h0
`define USF_ADDR_IER 4'h1
`define USF_ADDR_FCR_ISR 4'h2
`define USF_ADDR_LCR 4'h3
`define USF_ADDR_MCR 4'h4
`define USF_ADDR_LSR 4'h5
`define USF_ADDR_MSR 4'h6
`define USF_ADDR_SPR 4'h7
`define USF_ADDR_DIVLO 4'h8
`define USF_ADDR_DIVHI 4'h9
`define USF_ADDR_DIVFR 4'hA
`define USF_ADDR_FEATURE_CONTROL_REG 4'hB
`define USF_ADDR_EFR 4'hC
`define USF_ADDR_FLOWSEL 4'hD
`define USF_ADDR_FLOWSTAT 4'hE
`define USF_ADDR_IRQ 4'hF

// flow character, level and threshold select values written at the flow select slot
`define USF_SEL_STOP1 4'h0
`define USF_SEL_STOP2 4'h1
`define USF_SEL_RES1 4'h2
`define USF_SEL_RES2 4'h3
`define USF_SEL_TXLVL 4'h4
`define USF_SEL_TXTRG 4'h5
`define USF_SEL_RXLVL 4'h6
`define USF_SEL_RXTRG 4'h7

// flow status bits
`define USF_FS_TX_RESUME 3
`define USF_FS_TX_STOP 2
`define USF_FS_RX_RESUME 1
`define USF_FS_RX_STOP 0

// irq status bits
`define USF_IRQ_FLOW 0
`define USF_IRQ_RX 1

// reset values
`define USF_RST_ZERO 8'h00
`define USF_RST_DIVLO 8'h01
`define USF_RST_ISR 8'h01
`define USF_RST_LSR 8'h60
`define USF_RST_SPR 8'hFF
`define USF_LSR_RX_READY 0

// timing: receive interrupt within one baud tick of the stop bit
`define USF_BCLK_PERIODS 1

`endif

//--- rtl/usf_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module usf_sync #(
  parameter W = 4
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta;

  // plain two-stage chain; reset to the idle high of active low pins
  // so that no false level change follows reset
  always @(posedge clk) begin
    if (rst) begin
      meta <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // usf_sync
`default_nettype wire

//--- rtl/usf_flowstat.v
// Purpose: per-bit sticky flow character status with read clear
// Assumes: event pulses one cycle long, on clk
// Notes: the set wins over a read clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "usf_map.vh"
module usf_flowstat (
  input wire clk,
  input wire rst,
  input wire flow_enabled,
  input wire clear_rd,
  input wire tx_resume_sent,
  input wire tx_stop_sent,
  input wire rx_resume_seen,
  input wire rx_stop_seen,
  output wire [7:0] status
);
  wire [3:0] ev;
  reg [3:0] bits;
  genvar i;

  assign ev = {tx_resume_sent, tx_stop_sent, rx_resume_seen, rx_stop_seen};
  assign status = {4'h0, bits}; // upper nibble reserved

  // one sticky bit per event; newest of a tx or rx pair replaces the other
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst || !flow_enabled) begin
          bits[i] <= 1'b0; // forced clear while flow control off
        end else if (ev[i]) begin
          bits[i] <= 1'b1;
        end else if (ev[i ^ 1]) begin
          bits[i] <= 1'b0; // only the most recent character of a direction
        end else if (clear_rd) begin
          bits[i] <= 1'b0; // read clears
        end
      end
    end
  endgenerate
endmodule // usf_flowstat
`default_nettype wire

//--- dv/usf_regs_monitor.sv
// Purpose: port checks for the channel register bank
// Assumes: one clk, synchronous active high rst held two or more cycles
// Notes: change checks rely on reset masking the drop to reset values
`timescale 1ns/1ps
`default_nettype none
`include "usf_map.vh"
module usf_regs_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_resume_sent,
  input wire logic tx_stop_sent,
  input wire logic rx_resume_seen,
  input wire logic rx_stop_seen,
  input wire logic rx_char_done,
  input wire logic serial_out,
  input wire logic infrared_tx_out,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic [7:0] stop_char_first_o,
  input wire logic [7:0] stop_char_second_o,
  input wire logic [7:0] resume_char_first_o,
  input wire logic [7:0] resume_char_second_o,
  input wire logic [3:0] tx_flow_sel,
  input wire logic [3:0] rx_flow_sel,
  input wire logic [7:0] transmit_holding_o,
  input wire logic transmit_load,
  input wire logic irq
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // outputs at the first edge after reset release
  property p_rst_pins;
    $fell(rst) |-> serial_out && !infrared_tx_out && rts_n && dtr_n && !irq && rdata == 8'h00;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pin levels wrong after reset");
  property p_rst_flow;
    $fell(rst) |-> {stop_char_first_o, stop_char_second_o, resume_char_first_o,
      resume_char_second_o} == 32'h0000_0000 && tx_flow_sel == 4'h0 && rx_flow_sel == 4'h0;
  endproperty
  a_rst_flow: assert property (p_rst_flow) else $error("flow state not cleared");
  // characters move only by a write through the flow slot
  property p_char_cause;
    $changed({stop_char_first_o, stop_char_second_o, resume_char_first_o,
      resume_char_second_o}) |-> $past(wr) && $past(addr) == `USF_ADDR_FLOWSTAT;
  endproperty
  a_char_cause: assert property (p_char_cause) else $error("char changed unasked");
  property p_sel_follow;
    wr && addr == `USF_ADDR_EFR |=> {tx_flow_sel[3:2], rx_flow_sel[3:2]} == 4'h0 &&
      {4'h0, tx_flow_sel[1:0], rx_flow_sel[1:0]} == ($past(wdata) & 8'h0F);
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("flow select mismatch");
  property p_sel_cause;
    $changed({tx_flow_sel, rx_flow_sel}) |-> $past(wr) && $past(addr) == `USF_ADDR_EFR;
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("flow select moved unasked");
  property p_hold_load;
    wr && addr == `USF_ADDR_HOLDING |-> ##1 transmit_holding_o == $past(wdata) ##[0:1] transmit_load;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("holding write lost");
  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  // a read of the irq status with no event pending drops the line
  property p_irq_clear;
    rd && addr == `USF_ADDR_IRQ && !(tx_resume_sent || tx_stop_sent || rx_resume_seen ||
      rx_stop_seen || rx_char_done) |=> !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq kept after read");
  property p_modem_out;
    $changed({rts_n, dtr_n}) |-> $past(wr, 2) && $past(addr, 2) == `USF_ADDR_MCR;
  endproperty
  a_modem_out: assert property (p_modem_out) else $error("modem output moved");
endmodule // usf_regs_monitor
bind usf_regs usf_regs_monitor usf_regs_monitor_inst (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_resume_sent(tx_resume_sent),
  .tx_stop_sent(tx_stop_sent), .rx_resume_seen(rx_resume_seen), .rx_stop_seen(rx_stop_seen),
  .rx_char_done(rx_char_done), .serial_out(serial_out), .infrared_tx_out(infrared_tx_out),
  .rts_n(rts_n), .dtr_n(dtr_n), .stop_char_first_o(stop_char_first_o),
  .stop_char_second_o(stop_char_second_o), .resume_char_first_o(resume_char_first_o),
  .resume_char_second_o(resume_char_second_o), .tx_flow_sel(tx_flow_sel),
  .rx_flow_sel(rx_flow_sel), .transmit_holding_o(transmit_holding_o),
  .transmit_load(transmit_load), .irq(irq));
`default_nettype wire

//--- dv/usf_peer.sv
// Purpose: far-side serial peer raising flow and receive events
// Assumes: bench asks for one event per go, kind 0 to 4
// Notes: rx_char means nothing without rx_char_done, so it drifts between
`timescale 1ns/1ps
`default_nettype none
module usf_peer (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  output logic tx_resume_sent,
  output logic tx_stop_sent,
  output logic rx_resume_seen,
  output logic rx_stop_seen,
  output logic rx_char_done,
  output logic [7:0] rx_char,
  output logic [3:0] modem_in_n,
  output logic bclk_tick
);
  logic [3:0] div = 4'h0;
  // idle peer leaves its modem lines inactive high
  assign modem_in_n = 4'hF;
  initial rx_char = 8'h00;
  // one pulse per go: tx resume, tx stop, rx resume, rx stop, rx char
  always @(posedge clk) begin
    {rx_char_done, rx_stop_seen, rx_resume_seen, tx_stop_sent, tx_resume_sent} <=
      go ? (5'h01 << kind) : 5'h00;
    rx_char <= go ? 8'h5A : ~rx_char;
    div <= div + 4'h1;
    bclk_tick <= (div == 4'hF);
  end
endmodule // usf_peer
`default_nettype wire

//--- dv/usf_regs_tb.sv
// Purpose: self-checking bench for the channel register bank
// Assumes: 250 MHz clk, inputs driven by non-blocking assignment at the edge
// Notes: fifo levels and transmit line tied idle; their paths go unchecked
`timescale 1ns/1ps
`default_nettype none
`include "usf_map.vh"
module usf_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [7:0] v;
  integer n_errors = 0;
  integer samples_checked = 0;
  wire [7:0] rdata, rx_char, transmit_holding_o;
  wire [7:0] stop_char_first_o, stop_char_second_o, resume_char_first_o, resume_char_second_o;
  wire [3:0] modem_in_n;
  wire bclk_tick, tx_resume_sent, tx_stop_sent, rx_resume_seen, rx_stop_seen, rx_char_done;
  wire serial_out, infrared_tx_out, rts_n, dtr_n, irq;
  // 4 ns period
  always #2 clk = ~clk;
  usf_peer usf_peer_inst (.clk(clk), .go(go), .kind(kind), .tx_resume_sent(tx_resume_sent),
    .tx_stop_sent(tx_stop_sent), .rx_resume_seen(rx_resume_seen), .rx_stop_seen(rx_stop_seen),
    .rx_char_done(rx_char_done), .rx_char(rx_char), .modem_in_n(modem_in_n),
    .bclk_tick(bclk_tick));
  usf_regs usf_regs_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bclk_tick(bclk_tick), .tx_resume_sent(tx_resume_sent),
    .tx_stop_sent(tx_stop_sent), .rx_resume_seen(rx_resume_seen), .rx_stop_seen(rx_stop_seen),
    .rx_char_done(rx_char_done), .rx_char(rx_char), .modem_in_n(modem_in_n),
    .tx_fifo_count(8'h00), .rx_fifo_count(8'h00), .tx_idle(1'b1), .tx_serial(1'b1),
    .tx_serial_en(1'b0), .serial_out(serial_out), .infrared_tx_out(infrared_tx_out),
    .rts_n(rts_n), .dtr_n(dtr_n), .stop_char_first_o(stop_char_first_o),
    .stop_char_second_o(stop_char_second_o), .resume_char_first_o(resume_char_first_o),
    .resume_char_second_o(resume_char_second_o), .tx_flow_sel(), .rx_flow_sel(),
    .transmit_holding_o(transmit_holding_o), .transmit_load(), .irq(irq));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample it there
  task rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(v, e);
  endtask
  task ev(input logic [2:0] k);
    @(posedge clk);
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task chk_outs;
    chk({4'h0, serial_out, infrared_tx_out, rts_n, dtr_n}, 8'h0B);
    chk(stop_char_first_o | stop_char_second_o | resume_char_first_o | resume_char_second_o,
      8'h00);
  endtask
  task t_reset;
    chk_outs;
    rchk(`USF_ADDR_DIVLO, `USF_RST_DIVLO);
    rchk(`USF_ADDR_DIVHI, 8'h00);
    rchk(`USF_ADDR_DIVFR, 8'h00);
    rchk(`USF_ADDR_FCR_ISR, `USF_RST_ISR);
    rchk(`USF_ADDR_LSR, `USF_RST_LSR);
    rchk(`USF_ADDR_SPR, `USF_RST_SPR);
    rchk(`USF_ADDR_IER, 8'h00);
    rchk(`USF_ADDR_LCR, 8'h00);
    rchk(`USF_ADDR_MCR, 8'h00);
    rchk(`USF_ADDR_FEATURE_CONTROL_REG, 8'h00);
    rchk(`USF_ADDR_EFR, 8'h00);
    rchk(`USF_ADDR_FLOWSEL, 8'h00);
    rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    rchk(`USF_ADDR_IRQ, 8'h00);
    rchk(`USF_ADDR_MSR, {~modem_in_n, 4'h0});
    chk(v & 8'h0F, 8'h00);
    wr_reg(`USF_ADDR_FLOWSEL, {4'h0, `USF_SEL_TXTRG});
    rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    wr_reg(`USF_ADDR_FLOWSEL, {4'h0, `USF_SEL_RXTRG});
    rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    $display("t_reset done");
  endtask
  task t_chars;
    for (int i = 0; i < 4; i++) begin
      wr_reg(`USF_ADDR_FLOWSEL, {4'h0, i[3:0]});
      wr_reg(`USF_ADDR_FLOWSTAT, 8'hA0 + i[7:0]);
    end
    #1;
    chk(stop_char_first_o, 8'hA0);
    chk(stop_char_second_o, 8'hA1);
    chk(resume_char_first_o, 8'hA2);
    chk(resume_char_second_o, 8'hA3);
    rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    $display("t_chars done");
  endtask
  // each event alone, then last-one-wins on the tx pair, then a disable
  task t_status;
    wr_reg(`USF_ADDR_EFR, 8'h0F);
    for (int k = 0; k < 4; k++) begin
      ev(k[2:0]);
      rchk(`USF_ADDR_FLOWSTAT, 8'h08 >> k);
      rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    end
    ev(3'd1);
    ev(3'd0);
    ev(3'd3);
    rchk(`USF_ADDR_FLOWSTAT, 8'h09);
    ev(3'd2);
    wr_reg(`USF_ADDR_EFR, 8'h00);
    ev(3'd1);
    rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    wr_reg(`USF_ADDR_EFR, 8'h0F);
    rchk(`USF_ADDR_FLOWSTAT, 8'h00);
    $display("t_status done");
  endtask
  task t_irq;
    rchk(`USF_ADDR_IRQ, 8'h01);
    wr_reg(`USF_ADDR_IRQ, 8'h20);
    ev(3'd4);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    rchk(`USF_ADDR_IRQ, 8'h22);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`USF_ADDR_IER, 8'h01);
    rchk(`USF_ADDR_FCR_ISR, 8'h04);
    rchk(`USF_ADDR_HOLDING, 8'h5A);
    rchk(`USF_ADDR_FCR_ISR, `USF_RST_ISR);
    ev(3'd3);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    rchk(`USF_ADDR_IRQ, 8'h21);
    $display("t_irq done");
  endtask
  // reset in mid-run after scratch, modem and holding writes
  task t_rerst;
    wr_reg(`USF_ADDR_SPR, 8'h5A);
    rchk(`USF_ADDR_SPR, 8'h5A);
    wr_reg(`USF_ADDR_MCR, 8'h03);
    wr_reg(`USF_ADDR_HOLDING, 8'hC3);
    #1 chk(transmit_holding_o, 8'hC3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(`USF_ADDR_SPR, `USF_RST_SPR);
    rchk(`USF_ADDR_EFR, 8'h00);
    chk_outs;
    $display("t_rerst done");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    n_errors = n_errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_chars;
    t_status;
    t_irq;
    t_rerst;
    report_and_stop;
  end
endmodule // usf_regs_tb
`default_nettype wire
